/* File: src/clkstop_pkg.sv */
// package: constants and carriers for the clock-stop and boot-select block
package clkstop_pkg;

	// instruction decode
	localparam logic [31:0] CLOCK_STOP_OPCODE    = 32'h0600_0001;

	// wake timing in input clock periods
	localparam int          WAKE_HOLD_CLKS       = 4;
	localparam int          RESTART_DELAY_CLKS   = 2;
	localparam int          SERVICE_HOLD_CLKS    = 4;
	localparam logic [2:0]  WAKE_HOLD_CNT        = 3'(WAKE_HOLD_CLKS);
	localparam logic [2:0]  RESTART_DELAY_CNT    = 3'(RESTART_DELAY_CLKS);
	localparam logic [2:0]  SERVICE_HOLD_CNT     = 3'(SERVICE_HOLD_CLKS);

	// external interrupt lines: nmi at bit 4, flag pins 3..0
	localparam int          NUM_WAKE_PINS        = 5;

	// boot select codes, pin 3 down to pin 0
	localparam logic [3:0]  BOOT_SEL_LOW_RAM     = 4'hd;
	localparam logic [3:0]  BOOT_SEL_LOCAL_0     = 4'hb;
	localparam logic [3:0]  BOOT_SEL_MID_RAM     = 4'h9;
	localparam logic [3:0]  BOOT_SEL_GLOBAL_0    = 4'h7;
	localparam logic [3:0]  BOOT_SEL_GLOBAL_40   = 4'h5;
	localparam logic [3:0]  BOOT_SEL_GLOBAL_80   = 4'h3;
	localparam logic [3:0]  BOOT_SEL_RESERVED    = 4'h1;
	localparam logic [3:0]  BOOT_SEL_COMM_PORT   = 4'hf;

	// boot source addresses
	localparam logic [31:0] BOOT_ADDR_LOW_RAM    = 32'h0030_0000;
	localparam logic [31:0] BOOT_ADDR_LOCAL_0    = 32'h4000_0000;
	localparam logic [31:0] BOOT_ADDR_MID_RAM    = 32'h0080_0000;
	localparam logic [31:0] BOOT_ADDR_GLOBAL_0   = 32'h8000_0000;
	localparam logic [31:0] BOOT_ADDR_GLOBAL_40  = 32'h8040_0000;
	localparam logic [31:0] BOOT_ADDR_GLOBAL_80  = 32'h8080_0000;

	// external address pin values
	localparam logic [23:0] PIN_ADDR_ZERO        = 24'h00_0000;
	localparam logic [23:0] PIN_ADDR_40          = 24'h40_0000;
	localparam logic [23:0] PIN_ADDR_80          = 24'h80_0000;

	typedef enum logic [2:0] {
		BOOT_NONE,
		BOOT_MEMORY,
		BOOT_LOCAL_BUS,
		BOOT_GLOBAL_BUS,
		BOOT_COMM_PORT,
		BOOT_TERMINATE
	} boot_kind_e;

	// decoded boot selection
	typedef struct packed {
		boot_kind_e  kind;
		logic [31:0] source_addr;
		logic [23:0] pin_addr;
		logic        local_strobe_zero;
		logic        global_strobe_zero;
	} boot_sel_s;

	// cpu-side controls during clock stop
	typedef struct packed {
		logic        cpu_run;
		logic        hold_address;
		logic        data_float;
		logic        controls_inactive;
	} stop_ctl_s;

endpackage : clkstop_pkg

/* File: src/clock_stop_wake_and_boot_select.sv */
// design: clock-stop power-down, wake timing, phase clocks and boot source select
//
// Overview of operation
// - opcode 06000001h enters clock-stop state
// - any pin low four clocks ends stop
// - clocks restart two input clocks later
// - phase clocks always stay 180 degrees apart
// - service only pre-enabled, held two cycles
// - any pin wakes; enabled ones get serviced
// - next instruction waits for interrupt return
// - emulation mode turns stop into idle
// - code 1101 boots from 0030 0000h
// - code 1011 boots local strobe zero
// - code 1001 boots from 80 0000h
// - code 0111 boots global 8000 0000h
// - code 0101 boots global 8040 0000h
// - code 0011 boots global 8080 0000h
// - code 0001 reserved, loader terminates
// - code 1111 boots from communication port
// - stop halts with phase one held high
// - stop keeps state, floats data, idles controls
`timescale 1ns/10ps

module clock_stop_wake_and_boot_select (
	// clock and reset
	input  wire logic                     i_clock,
	input  wire logic                     i_rst_n,
	// instruction execute stage
	input  wire logic                     i_instr_valid,
	input  wire logic [31:0]              i_instr_word,
	input  wire logic                     i_emulation_mode,
	input  wire logic                     i_return_exec,
	// external interrupt pins, active low: nmi at bit 4
	input  wire logic [4:0]               i_ext_irq_n,
	input  wire logic [4:0]               i_irq_enable,
	// phase clocks
	output logic                          o_phase_one_clock,
	output logic                          o_phase_three_clock,
	// power state
	output logic                          o_clock_stopped,
	output logic                          o_idle,
	output clkstop_pkg::stop_ctl_s        o_stop_ctl,
	output logic                          o_hold_next_instr,
	// interrupt service
	output logic                          o_irq_take,
	output logic [4:0]                    o_irq_take_vec,
	// boot selection
	output clkstop_pkg::boot_sel_s        o_boot_sel,
	output logic [3:0]                    o_boot_code
);

	typedef enum logic [1:0] {
		ST_RUN,
		ST_STOPPED,
		ST_RESTART
	} pwr_state_e;

	pwr_state_e             state_reg;
	logic [2:0]             cnt_reg;
	logic [4:0]             en_at_stop_reg;
	logic [4:0]             pin_low;
	logic [2:0]             low_cnt [5];
	logic                   wake_hit;
	logic                   is_stop_op;
	logic                   phase_reg;
	logic                   idle_reg;
	logic                   stopped_reg;
	logic                   hold_next_reg;
	logic                   take_reg;
	logic [4:0]             take_vec_reg;
	logic [4:0]             take_vec_next;
	logic                   boot_done_reg;
	logic [3:0]             boot_code_reg;
	clkstop_pkg::boot_sel_s boot_sel_reg;
	clkstop_pkg::boot_sel_s boot_sel_next;
	clkstop_pkg::stop_ctl_s stop_ctl_reg;

	assign pin_low    = ~i_ext_irq_n;
	assign is_stop_op = i_instr_valid && (i_instr_word == clkstop_pkg::CLOCK_STOP_OPCODE);

	// ------------------------------------------------------------
	// per-pin low-time counters
	// ------------------------------------------------------------
	// counters saturate at the hold figure; any pin may wake, enabled or not
	for (genvar g = 0; g < clkstop_pkg::NUM_WAKE_PINS; g++) begin : g_low
		always_ff @(posedge i_clock) begin
			if (!i_rst_n || !pin_low[g]) begin
				low_cnt[g] <= 3'h0;
			end else if (low_cnt[g] != clkstop_pkg::WAKE_HOLD_CNT) begin
				low_cnt[g] <= low_cnt[g] + 3'h1;
			end
		end
	end

	// saturated count still wakes: a pin held low across stop entry
	always_comb begin
		wake_hit = 1'b0;
		for (int i = 0; i < clkstop_pkg::NUM_WAKE_PINS; i++) begin
			if (low_cnt[i] >= clkstop_pkg::WAKE_HOLD_CNT - 3'h1 && pin_low[i]) begin
				wake_hit = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// power state machine
	// ------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			state_reg      <= ST_RUN;
			cnt_reg        <= 3'h0;
			en_at_stop_reg <= 5'h00;
		end else begin
			case (state_reg)
				ST_RUN: begin
					// emulation keeps clocks running; treated as idle
					if (is_stop_op && !i_emulation_mode) begin
						state_reg      <= ST_STOPPED;
						en_at_stop_reg <= i_irq_enable;
					end
				end
				ST_STOPPED: begin
					if (wake_hit) begin
						state_reg <= ST_RESTART;
						cnt_reg   <= 3'h1;
					end
				end
				ST_RESTART: begin
					if (cnt_reg == clkstop_pkg::RESTART_DELAY_CNT) begin
						state_reg <= ST_RUN;
						cnt_reg   <= 3'h0;
					end else begin
						cnt_reg <= cnt_reg + 3'h1;
					end
				end
				default: begin
					state_reg <= ST_RUN;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// phase clocks
	// ------------------------------------------------------------
	// one phase bit drives both outputs, so they can never overlap
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			phase_reg           <= 1'b0;
			o_phase_one_clock   <= 1'b1;
			o_phase_three_clock <= 1'b0;
		end else begin
			if (state_reg == ST_RUN && !(is_stop_op && !i_emulation_mode)) begin
				phase_reg <= ~phase_reg;
			end else begin
				phase_reg <= 1'b1;
			end
			// restart always comes up from phase one high, since phase_reg is held at 1 until run
			o_phase_one_clock   <= phase_reg;
			o_phase_three_clock <= ~phase_reg;
		end
	end

	// ------------------------------------------------------------
	// status and bus control during stop
	// ------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			stopped_reg  <= 1'b0;
			idle_reg     <= 1'b0;
			stop_ctl_reg <= '{cpu_run: 1'b1, default: 1'b0};
		end else begin
			stopped_reg  <= (state_reg != ST_RUN);
			idle_reg     <= is_stop_op && i_emulation_mode;
			stop_ctl_reg.cpu_run           <= (state_reg == ST_RUN);
			stop_ctl_reg.hold_address      <= (state_reg != ST_RUN);
			stop_ctl_reg.data_float        <= (state_reg != ST_RUN);
			stop_ctl_reg.controls_inactive <= (state_reg != ST_RUN);
		end
	end

	// ------------------------------------------------------------
	// wake interrupt service
	// ------------------------------------------------------------
	// pins enabled at entry and held two phase-one cycles are serviced
	always_comb begin
		take_vec_next = 5'h00;
		for (int i = 0; i < clkstop_pkg::NUM_WAKE_PINS; i++) begin
			take_vec_next[i] = en_at_stop_reg[i] && pin_low[i]
				&& (low_cnt[i] >= clkstop_pkg::SERVICE_HOLD_CNT - 3'h1);
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			take_reg      <= 1'b0;
			take_vec_reg  <= 5'h00;
			hold_next_reg <= 1'b0;
		end else begin
			if (state_reg == ST_STOPPED && wake_hit) begin
				take_vec_reg <= take_vec_next;
				take_reg     <= |take_vec_next;
			end else begin
				take_vec_reg <= 5'h00;
				take_reg     <= 1'b0;
			end
			// stall the instruction after the stop until return executes
			if (state_reg == ST_STOPPED && wake_hit && |take_vec_next) begin
				hold_next_reg <= 1'b1;
			end else if (i_return_exec) begin
				hold_next_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// boot source selection
	// ------------------------------------------------------------
	always_comb begin
		boot_sel_next = '{kind: clkstop_pkg::BOOT_MEMORY, source_addr: 32'h0,
			pin_addr: clkstop_pkg::PIN_ADDR_ZERO, default: 1'b0};
		case (i_ext_irq_n[3:0])
			clkstop_pkg::BOOT_SEL_LOW_RAM: begin
				boot_sel_next.source_addr = clkstop_pkg::BOOT_ADDR_LOW_RAM;
			end
			clkstop_pkg::BOOT_SEL_LOCAL_0: begin
				boot_sel_next.kind              = clkstop_pkg::BOOT_LOCAL_BUS;
				boot_sel_next.source_addr       = clkstop_pkg::BOOT_ADDR_LOCAL_0;
				boot_sel_next.local_strobe_zero = 1'b1;
			end
			clkstop_pkg::BOOT_SEL_MID_RAM: begin
				boot_sel_next.source_addr = clkstop_pkg::BOOT_ADDR_MID_RAM;
			end
			clkstop_pkg::BOOT_SEL_GLOBAL_0: begin
				boot_sel_next.kind               = clkstop_pkg::BOOT_GLOBAL_BUS;
				boot_sel_next.source_addr        = clkstop_pkg::BOOT_ADDR_GLOBAL_0;
				boot_sel_next.global_strobe_zero = 1'b1;
			end
			clkstop_pkg::BOOT_SEL_GLOBAL_40: begin
				boot_sel_next.kind               = clkstop_pkg::BOOT_GLOBAL_BUS;
				boot_sel_next.source_addr        = clkstop_pkg::BOOT_ADDR_GLOBAL_40;
				boot_sel_next.pin_addr           = clkstop_pkg::PIN_ADDR_40;
				boot_sel_next.global_strobe_zero = 1'b1;
			end
			clkstop_pkg::BOOT_SEL_GLOBAL_80: begin
				boot_sel_next.kind               = clkstop_pkg::BOOT_GLOBAL_BUS;
				boot_sel_next.source_addr        = clkstop_pkg::BOOT_ADDR_GLOBAL_80;
				boot_sel_next.pin_addr           = clkstop_pkg::PIN_ADDR_80;
				boot_sel_next.global_strobe_zero = 1'b1;
			end
			clkstop_pkg::BOOT_SEL_RESERVED: begin
				boot_sel_next.kind = clkstop_pkg::BOOT_TERMINATE;
			end
			clkstop_pkg::BOOT_SEL_COMM_PORT: begin
				boot_sel_next.kind = clkstop_pkg::BOOT_COMM_PORT;
			end
			default: begin
				// undefined codes terminate like the reserved one
				boot_sel_next.kind = clkstop_pkg::BOOT_TERMINATE;
			end
		endcase
	end

	// first clock after reset release captures once, then holds
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			boot_done_reg <= 1'b0;
			boot_code_reg <= 4'h0;
			boot_sel_reg  <= '{kind: clkstop_pkg::BOOT_NONE, source_addr: 32'h0,
				pin_addr: clkstop_pkg::PIN_ADDR_ZERO, default: 1'b0};
		end else if (!boot_done_reg) begin
			boot_done_reg <= 1'b1;
			boot_code_reg <= i_ext_irq_n[3:0];
			boot_sel_reg  <= boot_sel_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_clock_stopped   = stopped_reg;
	assign o_idle            = idle_reg;
	assign o_stop_ctl        = stop_ctl_reg;
	assign o_hold_next_instr = hold_next_reg;
	assign o_irq_take        = take_reg;
	assign o_irq_take_vec    = take_vec_reg;
	assign o_boot_sel        = boot_sel_reg;
	assign o_boot_code       = boot_code_reg;

endmodule : clock_stop_wake_and_boot_select

/* File: verification/clock_stop_wake_and_boot_select_properties.sv */
// checker: timing properties of clock stop, wake and boot select
`timescale 1ns/10ps

module clock_stop_wake_and_boot_select_checker (
	// clock and reset
	input wire logic                   i_clock,
	input wire logic                   i_rst_n,
	// stimulus side
	input wire logic                   i_instr_valid,
	input wire logic [31:0]            i_instr_word,
	input wire logic                   i_emulation_mode,
	input wire logic                   i_return_exec,
	input wire logic [4:0]             i_ext_irq_n,
	// design outputs
	input wire logic                   o_phase_one_clock,
	input wire logic                   o_phase_three_clock,
	input wire logic                   o_clock_stopped,
	input wire logic                   o_idle,
	input wire clkstop_pkg::stop_ctl_s o_stop_ctl,
	input wire logic                   o_hold_next_instr,
	input wire logic                   o_irq_take,
	input wire logic [4:0]             o_irq_take_vec,
	input wire clkstop_pkg::boot_sel_s o_boot_sel,
	input wire logic [3:0]             o_boot_code
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	logic stop_op;
	assign stop_op = i_instr_valid && i_instr_word == clkstop_pkg::CLOCK_STOP_OPCODE;

	a_phase_opposite: assert property (o_phase_three_clock == !o_phase_one_clock)
		else $error("phase clocks not opposite");
	a_stop_entry: assert property (stop_op && !i_emulation_mode && !o_clock_stopped
		|-> ##2 o_clock_stopped) else $error("stop opcode did not stop clocks");
	a_emul_idle: assert property (stop_op && i_emulation_mode && !o_clock_stopped
		|=> o_idle ##1 !o_clock_stopped) else $error("emulation stop not idle");
	a_stop_phase_high: assert property (o_clock_stopped |-> o_phase_one_clock)
		else $error("phase one low while stopped");
	a_stop_outputs: assert property (o_clock_stopped |-> o_stop_ctl == 4'h7)
		else $error("bus controls wrong while stopped");
	a_run_outputs: assert property (!o_clock_stopped |-> o_stop_ctl == 4'h8)
		else $error("bus controls wrong while running");
	// stopped output trails the return to run by one clock
	a_wake_delay: assert property ((o_clock_stopped && !i_ext_irq_n[0])[*4]
		|-> ##3 o_clock_stopped ##1 !o_clock_stopped) else $error("wake restart timing wrong");
	a_take_cause: assert property (o_irq_take |-> o_hold_next_instr
		&& o_irq_take_vec != 5'h00
		&& (o_irq_take_vec & $past(i_ext_irq_n)) == 5'h00) else $error("bad service vector");
	a_take_single: assert property (o_irq_take |=> !o_irq_take)
		else $error("service pulse too long");
	a_hold_release: assert property (o_hold_next_instr && i_return_exec
		|=> !o_hold_next_instr || o_irq_take) else $error("hold not released");
	a_hold_cause: assert property ($rose(o_hold_next_instr) |-> o_irq_take)
		else $error("hold without service");
	a_boot_stable: assert property ($past(i_rst_n, 2) |-> $stable(o_boot_code)
		&& $stable(o_boot_sel)) else $error("boot selection changed");
	a_local_strobe: assert property ($past(i_rst_n, 2) |-> o_boot_sel.local_strobe_zero
		== (o_boot_code == clkstop_pkg::BOOT_SEL_LOCAL_0)) else $error("local strobe wrong");

	c_stop: cover property ($rose(o_clock_stopped));
	c_take: cover property (o_irq_take);
	c_idle: cover property (o_idle);
endmodule : clock_stop_wake_and_boot_select_checker

bind clock_stop_wake_and_boot_select clock_stop_wake_and_boot_select_checker u_chk (
	.i_clock(i_clock), .i_rst_n(i_rst_n), .i_instr_valid(i_instr_valid),
	.i_instr_word(i_instr_word), .i_emulation_mode(i_emulation_mode),
	.i_return_exec(i_return_exec), .i_ext_irq_n(i_ext_irq_n),
	.o_phase_one_clock(o_phase_one_clock), .o_phase_three_clock(o_phase_three_clock),
	.o_clock_stopped(o_clock_stopped), .o_idle(o_idle), .o_stop_ctl(o_stop_ctl),
	.o_hold_next_instr(o_hold_next_instr), .o_irq_take(o_irq_take),
	.o_irq_take_vec(o_irq_take_vec), .o_boot_sel(o_boot_sel), .o_boot_code(o_boot_code));

/* File: verification/clock_stop_wake_and_boot_select_tb_top.sv */
// testbench: clock stop, wake service and boot selection
`timescale 1ns/10ps

module clock_stop_wake_and_boot_select_tb_top;
	logic i_clock, i_rst_n, i_instr_valid, i_emulation_mode, i_return_exec;
	logic o_phase_one_clock, o_phase_three_clock, o_clock_stopped, o_idle;
	logic o_hold_next_instr, o_irq_take;
	logic [31:0] i_instr_word;
	logic [4:0] i_ext_irq_n, i_irq_enable, o_irq_take_vec;
	logic [3:0] o_boot_code;
	clkstop_pkg::stop_ctl_s o_stop_ctl;
	clkstop_pkg::boot_sel_s o_boot_sel;
	int compares, miscompares;

	clock_stop_wake_and_boot_select uut (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_instr_valid(i_instr_valid), .i_instr_word(i_instr_word),
		.i_emulation_mode(i_emulation_mode), .i_return_exec(i_return_exec),
		.i_ext_irq_n(i_ext_irq_n), .i_irq_enable(i_irq_enable),
		.o_phase_one_clock(o_phase_one_clock), .o_phase_three_clock(o_phase_three_clock),
		.o_clock_stopped(o_clock_stopped), .o_idle(o_idle), .o_stop_ctl(o_stop_ctl),
		.o_hold_next_instr(o_hold_next_instr), .o_irq_take(o_irq_take),
		.o_irq_take_vec(o_irq_take_vec), .o_boot_sel(o_boot_sel), .o_boot_code(o_boot_code));
	wake_pin_source src (.i_clock(i_clock), .o_ext_irq_n(i_ext_irq_n));

	always #2.5 i_clock = ~i_clock;

	task automatic step(input int n);
		repeat (n) begin
			@(posedge i_clock);
			#1;
		end
	endtask : step

	task automatic check_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask : check_bit

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask : check_word

	task automatic test_boot(input logic [3:0] code, input clkstop_pkg::boot_kind_e kind,
			input logic [31:0] addr, input logic [1:0] bus);
		i_rst_n = 1'b0;
		src.set_level({1'b1, code});
		step(2);
		i_rst_n = 1'b1;
		step(1);
		src.set_level(5'h1f);
		step(2);
		check_word({28'h0, o_boot_code}, {28'h0, code});
		check_word({29'h0, o_boot_sel.kind}, {29'h0, kind});
		if (addr != 32'h0) check_word(o_boot_sel.source_addr, addr);
		if (bus != 2'd0) begin
			check_word({8'h00, o_boot_sel.pin_addr}, {8'h00, addr[23:0]});
		end
		check_bit(o_boot_sel.local_strobe_zero, bus == 2'd1);
		check_bit(o_boot_sel.global_strobe_zero, bus == 2'd2);
		$display("test boot code %h done", code);
	endtask : test_boot

	task automatic enter_stop();
		i_instr_valid = 1'b1;
		i_instr_word = clkstop_pkg::CLOCK_STOP_OPCODE;
		step(1);
		i_instr_valid = 1'b0;
		i_instr_word = 32'h0;
		step(2);
		check_bit(o_clock_stopped, 1'b1);
		check_bit(o_phase_one_clock, 1'b1);
		check_word({28'h0, o_stop_ctl}, 32'h7);
	endtask : enter_stop

	task automatic wake_check(input logic [4:0] mask, input logic [4:0] expv);
		logic [4:0] vec;
		logic ph;
		int fall_at;
		int exp_fall;
		vec = 5'h00;
		fall_at = -1;
		// four low edges, two restart clocks, then one clock of output lag
		exp_fall = clkstop_pkg::WAKE_HOLD_CLKS + clkstop_pkg::RESTART_DELAY_CLKS;
		fork
			src.pulse_low(mask, 4);
			for (int i = 0; i < 10; i++) begin
				step(1);
				if (o_irq_take === 1'b1) vec = o_irq_take_vec;
				if (o_clock_stopped === 1'b0 && fall_at < 0) fall_at = i;
			end
		join
		check_word({27'h0, vec}, {27'h0, expv});
		check_word(32'(fall_at), 32'(exp_fall));
		check_bit(o_clock_stopped, 1'b0);
		check_word({28'h0, o_stop_ctl}, 32'h8);
		ph = o_phase_one_clock;
		step(1);
		check_bit(o_phase_one_clock, ~ph);
		check_bit(o_phase_three_clock, ph);
		check_bit(o_hold_next_instr, expv != 5'h00);
		if (expv != 5'h00) begin
			i_return_exec = 1'b1;
			step(1);
			i_return_exec = 1'b0;
			step(1);
			check_bit(o_hold_next_instr, 1'b0);
		end
	endtask : wake_check

	task automatic test_wake(input logic [4:0] mask, input logic [4:0] expv);
		enter_stop();
		// enables raised after entry must not make a pin serviceable
		i_irq_enable = 5'h1f;
		wake_check(mask, expv);
		i_irq_enable = 5'h0f;
		$display("test wake mask %h done", mask);
	endtask : test_wake

	task automatic test_short_pulse();
		enter_stop();
		src.pulse_low(5'h01, 3);
		step(6);
		check_bit(o_clock_stopped, 1'b1);
		wake_check(5'h01, 5'h01);
		$display("test short pulse done");
	endtask : test_short_pulse

	task automatic test_emulation();
		logic seen, stopped;
		seen = 1'b0;
		stopped = 1'b0;
		i_emulation_mode = 1'b1;
		i_instr_valid = 1'b1;
		i_instr_word = clkstop_pkg::CLOCK_STOP_OPCODE;
		repeat (4) begin
			step(1);
			i_instr_valid = 1'b0;
			seen = seen | (o_idle === 1'b1);
			stopped = stopped | (o_clock_stopped === 1'b1);
		end
		i_emulation_mode = 1'b0;
		check_bit(seen, 1'b1);
		check_bit(stopped, 1'b0);
		$display("test emulation done");
	endtask : test_emulation

	task automatic final_report();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report

	initial begin
		i_clock = 1'b0;
		i_rst_n = 1'b0;
		i_instr_valid = 1'b0;
		i_instr_word = 32'h0;
		i_emulation_mode = 1'b0;
		i_return_exec = 1'b0;
		i_irq_enable = 5'h0f;
		compares = 0;
		miscompares = 0;
		step(12);
		i_rst_n = 1'b1;
		step(2);
		test_boot(4'hd, clkstop_pkg::BOOT_MEMORY, 32'h0030_0000, 2'd0);
		test_boot(4'hb, clkstop_pkg::BOOT_LOCAL_BUS, 32'h4000_0000, 2'd1);
		test_boot(4'h9, clkstop_pkg::BOOT_MEMORY, 32'h0080_0000, 2'd0);
		test_boot(4'h7, clkstop_pkg::BOOT_GLOBAL_BUS, 32'h8000_0000, 2'd2);
		test_boot(4'h5, clkstop_pkg::BOOT_GLOBAL_BUS, 32'h8040_0000, 2'd2);
		test_boot(4'h3, clkstop_pkg::BOOT_GLOBAL_BUS, 32'h8080_0000, 2'd2);
		test_boot(4'h1, clkstop_pkg::BOOT_TERMINATE, 32'h0, 2'd0);
		test_boot(4'h0, clkstop_pkg::BOOT_TERMINATE, 32'h0, 2'd0);
		test_boot(4'hf, clkstop_pkg::BOOT_COMM_PORT, 32'h0, 2'd0);
		test_emulation();
		test_wake(5'h01, 5'h01);
		test_wake(5'h10, 5'h00);
		test_wake(5'h04, 5'h04);
		test_short_pulse();
		final_report();
	end
endmodule : clock_stop_wake_and_boot_select_tb_top

/* File: verification/wake_pin_source.sv */
// partner model: external interrupt and boot-select pin source
`timescale 1ns/10ps

module wake_pin_source (
	// clock
	input  wire logic i_clock,
	// pins toward the device
	output logic [4:0] o_ext_irq_n
);
	// pins idle high when no source pulls them low
	initial o_ext_irq_n = 5'h1f;

	task automatic set_level(input logic [4:0] level);
		o_ext_irq_n = level;
	endtask : set_level

	// active-low pulse lasting whole input clocks
	task automatic pulse_low(input logic [4:0] mask, input int clocks);
		o_ext_irq_n = 5'h1f & ~mask;
		repeat (clocks) @(posedge i_clock);
		#1 o_ext_irq_n = 5'h1f;
	endtask : pulse_low
endmodule : wake_pin_source
